// ===== ebp_pkg.sv
/*
  Package for the eight channel byte PWM: register indices, field
  positions, reset values and the AHB-Lite carrier types.
  Assumes a 32-bit AHB-Lite bus where every register takes one word.
*/
package ebp_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [3:0] EBP_IDX_OUT_EN   = 4'h0;
  localparam logic [3:0] EBP_IDX_POLAR    = 4'h1;
  localparam logic [3:0] EBP_IDX_CONFIG   = 4'h2;
  localparam logic [3:0] EBP_IDX_DIV      = 4'h3;
  localparam logic [3:0] EBP_IDX_DUTY_LO  = 4'h4;
  localparam logic [3:0] EBP_IDX_DUTY_HI  = 4'h8;
  localparam logic [3:0] EBP_IDX_INT_CTRL = 4'hC;

  // Configuration register fields
  localparam int EBP_CFG_STAG_LSB   = 4;
  localparam int EBP_CFG_WIDTH_LSB  = 2;
  localparam int EBP_CFG_PHASE_BIT  = 1;
  localparam int EBP_CFG_SHORT_BIT  = 0;

  // Interrupt control and status fields
  localparam int EBP_INT_FLAG_BIT   = 7;
  localparam int EBP_INT_ADV_BIT    = 1;
  localparam int EBP_INT_IE_BIT     = 0;

  // Reset values
  localparam logic [7:0]  EBP_RST_BYTE = 8'h00;
  localparam logic [31:0] EBP_RST_DUTY = 32'h0000_0000;

  // Counter geometry and cycle-end advance in counts
  localparam int          EBP_MAX_WIDTH = 8;
  localparam logic [8:0]  EBP_ADV_LONG  = 9'h010;
  localparam logic [8:0]  EBP_ADV_SHORT = 9'h002;

  // AHB-Lite codes
  localparam logic [1:0]  EBP_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  EBP_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  EBP_HSIZE_BYTE    = 3'h0;
  localparam logic [2:0]  EBP_HSIZE_HALF    = 3'h1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  idx;
    logic [3:0]  lanes;
  } ebp_aphase_t;

endpackage

// ===== ebp_top.sv
/*
  Eight channel byte PWM with an AHB-Lite register slave, shared
  reference clock divider, per channel duty, polarity and enable,
  pair interleave and a cycle-end flag with interrupt.
  Assumes one clock (hclk) and a single AHB-Lite master; outputs go to
  pads whose direction pwm_oe_n sets from the enable bits.
*/
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - A channel drives its waveform only while its enable bit is set
// - Polarity one makes output idle high, active low; reset zero
// - Config bits 7..4 select interleave for pairs 6/7 down to 0/1
// - Read-only phase flag: one lets odd channels drive, zero even
// - Width code 00/01/10/11 selects 8/7/6/5 count bits
// - Short-cycle bit gives period 2^n-1, otherwise 2^n counts
// - Reference count advances once per divisor system clocks
// - Channel is active for the lesser of duty-byte and period counts of each period
// - Duty bytes packed four per word, lowest channel lowest byte
// - Cycle-end flag sets near period end, write one clears
// - Advance select fires the event 16 or 2 counts early
// - Interrupt raised from cycle-end flag only when enabled
module ebp_top
  import ebp_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // PWM pins, channel 0 in bit 0
  output logic [7:0]       pwm_out,
  output logic [7:0]       pwm_oe_n,
  // Interrupt
  output logic             irq
);

  logic [7:0]  out_en;
  logic [7:0]  polar;
  logic [3:0]  stag_en;
  logic [1:0]  width_sel;
  logic        short_sel;
  logic        phase;
  logic [7:0]  divisor;
  logic [31:0] duty_lo;
  logic [31:0] duty_hi;
  logic        cyc_flag;
  logic        adv_sel;
  logic        irq_en;

  logic [7:0]  pre_cnt;
  logic        tick;
  logic [8:0]  cnt;
  logic [8:0]  period;
  logic [8:0]  ev_cnt;
  logic        wrap;
  logic        ev;
  logic [63:0] duty_live;
  logic [7:0]  act;
  logic [7:0]  gated;

  ebp_aphase_t ap;
  ebp_aphase_t next_ap;
  logic [3:0]  lanes;
  logic [31:0] rd_word;
  logic        wr_int;

  // ---------------- AHB-Lite slave ----------------
  always_comb
  begin
    unique case (hsize)
      EBP_HSIZE_BYTE: lanes = 4'b0001 << haddr[1:0];
      EBP_HSIZE_HALF: lanes = haddr[1] ? 4'b1100 : 4'b0011;
      default:        lanes = 4'b1111;
    endcase
    next_ap.valid = hsel && hready &&
                    (htrans == EBP_HTRANS_NONSEQ ||
                     htrans == EBP_HTRANS_SEQ);
    next_ap.write = hwrite;
    next_ap.idx   = haddr[5:2];
    next_ap.lanes = lanes;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ap <= '0;
    else
      ap <= next_ap;
  end

  // Zero wait states; unmapped words read zero and ignore writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (haddr[5:2])
      EBP_IDX_OUT_EN:   rd_word = {24'h00_0000, out_en};
      EBP_IDX_POLAR:    rd_word = {24'h00_0000, polar};
      EBP_IDX_CONFIG:   rd_word = {24'h00_0000, stag_en, width_sel,
                                   phase, short_sel};
      EBP_IDX_DIV:      rd_word = {24'h00_0000, divisor};
      EBP_IDX_DUTY_LO:  rd_word = duty_lo;
      EBP_IDX_DUTY_HI:  rd_word = duty_hi;
      EBP_IDX_INT_CTRL: rd_word = {24'h00_0000, cyc_flag, 5'b0_0000,
                                   adv_sel, irq_en};
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is captured at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (next_ap.valid && !hwrite)
      hrdata <= rd_word;
    else
      hrdata <= 32'h0000_0000;
  end

  function automatic logic wr_hit(input ebp_aphase_t a,
                                  input logic [3:0] idx);
    wr_hit = a.valid && a.write && a.idx == idx && a.lanes[0];
  endfunction

  // ---------------- Control registers ----------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_en    <= EBP_RST_BYTE;
      polar     <= EBP_RST_BYTE;
      stag_en   <= 4'h0;
      width_sel <= 2'b00;
      short_sel <= 1'b0;
      divisor   <= EBP_RST_BYTE;
      adv_sel   <= 1'b0;
      irq_en    <= 1'b0;
    end
    else
    begin
      if (wr_hit(ap, EBP_IDX_OUT_EN))
        out_en <= hwdata[7:0];
      if (wr_hit(ap, EBP_IDX_POLAR))
        polar <= hwdata[7:0];
      if (wr_hit(ap, EBP_IDX_CONFIG))
      begin
        stag_en   <= hwdata[EBP_CFG_STAG_LSB +: 4];
        width_sel <= hwdata[EBP_CFG_WIDTH_LSB +: 2];
        short_sel <= hwdata[EBP_CFG_SHORT_BIT];
      end
      if (wr_hit(ap, EBP_IDX_DIV))
        divisor <= hwdata[7:0];
      if (wr_hit(ap, EBP_IDX_INT_CTRL))
      begin
        adv_sel <= hwdata[EBP_INT_ADV_BIT];
        irq_en  <= hwdata[EBP_INT_IE_BIT];
      end
    end
  end

  // Duty bytes, each lane writable on its own
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      duty_lo <= EBP_RST_DUTY;
      duty_hi <= EBP_RST_DUTY;
    end
    else
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (ap.valid && ap.write && ap.lanes[b] &&
            ap.idx == EBP_IDX_DUTY_LO)
          duty_lo[8*b +: 8] <= hwdata[8*b +: 8];
        if (ap.valid && ap.write && ap.lanes[b] &&
            ap.idx == EBP_IDX_DUTY_HI)
          duty_hi[8*b +: 8] <= hwdata[8*b +: 8];
      end
    end
  end

  // ---------------- Reference divider and counter ----------------
  // Counting to divisor-1 in eight bits makes zero wrap to 256
  // Lowering the divisor below the running prescaler count stalls ticks
  // until it wraps through 255: up to 256 idle clocks after the write
  assign tick = (pre_cnt == divisor - 8'h01);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_cnt <= 8'h00;
    else if (tick)
      pre_cnt <= 8'h00;
    else
      pre_cnt <= pre_cnt + 8'h01;
  end

  always_comb
  begin
    period = (9'h001 << (EBP_MAX_WIDTH - int'(width_sel)))
             - {8'h00, short_sel};
    ev_cnt = period - (adv_sel ? EBP_ADV_LONG : EBP_ADV_SHORT);
    wrap   = tick && (cnt >= period - 9'h001);
    ev     = tick && (cnt == ev_cnt);
  end

  // A width change that leaves cnt beyond the period wraps at the next tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt <= 9'h000;
    else if (wrap)
      cnt <= 9'h000;
    else if (tick)
      cnt <= cnt + 9'h001;
  end

  // Live duty reloads at the wrap so a period is never torn
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      duty_live <= {EBP_RST_DUTY, EBP_RST_DUTY};
    else if (wrap)
      duty_live <= {duty_hi, duty_lo};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase <= 1'b0;
    else if (wrap)
      phase <= ~phase;
  end

  // ---------------- Channel outputs ----------------
  always_comb
  begin
    for (int c = 0; c < 8; c++)
    begin
      act[c]   = {1'b0, duty_live[8*c +: 8]} > cnt;
      gated[c] = act[c] &&
                 (!stag_en[c/2] || (phase == c[0]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwm_out  <= 8'h00;
      pwm_oe_n <= 8'hFF;
    end
    else
    begin
      pwm_out  <= (gated & out_en) ^ polar;
      pwm_oe_n <= ~out_en;
    end
  end

  // ---------------- Cycle-end flag and interrupt ----------------
  assign wr_int = ap.valid && ap.write && ap.lanes[0] &&
                  ap.idx == EBP_IDX_INT_CTRL;

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cyc_flag <= 1'b0;
    else if (ev)
      cyc_flag <= 1'b1;
    else if (wr_int && hwdata[EBP_INT_FLAG_BIT])
      cyc_flag <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= cyc_flag && irq_en;
  end

  // ---------------- Assertions ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_chan_disabled: assert property (
    !out_en[3] |=> pwm_oe_n[3] && pwm_out[3] == $past(polar[3]))
    else $error("disabled channel not at idle level");

  a_polar_idle: assert property (
    out_en[0] && !gated[0] |=> pwm_out[0] == $past(polar[0]))
    else $error("idle level does not follow polarity");

  a_pair_interleave: assert property (
    stag_en[1] && !phase && out_en[3] |=> pwm_out[3] == $past(polar[3]))
    else $error("odd channel active in even phase");

  a_phase_toggle: assert property (
    wrap |=> phase != $past(phase))
    else $error("phase flag did not toggle at wrap");

  a_period_wrap: assert property (
    tick && cnt == period - 9'h001 |=> cnt == 9'h000)
    else $error("counter did not wrap at period end");

  a_div_spacing: assert property (
    tick && divisor == 8'h03 && $stable(divisor)
      |=> (!tick || divisor != 8'h03) ##1 (!tick || divisor != 8'h03)
      ##1 (tick || divisor != 8'h03))
    else $error("reference tick spacing wrong");

  a_duty_reload: assert property (
    wrap |=> duty_live == $past({duty_hi, duty_lo}))
    else $error("duty not reloaded at wrap");

  a_flag_set: assert property (
    tick && cnt == period - (adv_sel ? EBP_ADV_LONG : EBP_ADV_SHORT)
      |=> cyc_flag)
    else $error("cycle-end flag not set");

  a_irq_gate: assert property (
    !irq_en |=> !irq)
    else $error("interrupt raised while disabled");

  a_irq_follow: assert property (
    cyc_flag && irq_en |=> irq)
    else $error("interrupt missing while flag and enable set");

  a_flag_clear: assert property (
    wr_int && hwdata[EBP_INT_FLAG_BIT] && !ev |=> !cyc_flag)
    else $error("cycle-end flag not cleared by write one");

  a_oe_track: assert property (
    1'b1 |=> pwm_oe_n == ~$past(out_en))
    else $error("output enable does not follow enable bits");

  a_zero_wait: assert property (
    ap.valid |-> hreadyout && !hresp)
    else $error("slave not ready with OKAY");

  c_cycle_event: cover property (ev ##1 cyc_flag);
  c_interleave: cover property (stag_en[0] && wrap ##1 phase);
  c_irq: cover property (irq_en && ev ##2 irq);
  c_short_cycle: cover property (short_sel && width_sel == 2'b11 && wrap);
  c_div_zero: cover property (divisor == 8'h00 && tick);

endmodule

// ===== test_eight_channel_byte_pwm.sv
/*
  Self-checking bench for ebp_top: registers over AHB-Lite, duty,
  polarity, enables, width, period, divisor, interleave and cycle-end
  interrupt. Assumes the one slave's hreadyout serves as hready.
*/
`timescale 1ns/1ps
module test_eight_channel_byte_pwm
  import ebp_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  pwm_out;
  logic [7:0]  pwm_oe_n;
  logic        irq;
  logic [31:0] r;
  logic        rsp;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic [7:0]  pv;
  logic [31:0] amap [8] = '{0, 4, 8, 12, 16, 32, 48, 32'h0000_0014};
  int          bad_count;
  int          check_count;
  int          seed;
  int          i;
  int          n;
  int          c;
  int          c2;
  int          k;

  ebp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pwm_out(pwm_out),
    .pwm_oe_n(pwm_oe_n), .irq(irq));

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
      fail($sformatf("value %h expected %h", g, e));
  endtask

  task automatic chkn(input int g, input int e);
    check_count++;
    if (g != e)
      fail($sformatf("count %0d expected %0d", g, e));
  endtask

  function automatic int lim(input int d, input int p);
    return (d < p) ? d : p;
  endfunction

  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic [2:0] sz);
    int t;
    hsel <= 1'b1;
    htrans <= EBP_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    t = 0;
    do
    begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (hreadyout !== 1'b1)
    begin
      fail("address phase wait ran out");
      conclude;
    end
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 100);
    r = hrdata;
    rsp = hresp;
    if (t >= 100)
    begin
      fail("bus wait ran out");
      conclude;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 3'h2);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'b0, a, 32'h0000_0000, 3'h2);
    chk32(r & m, e);
    chk32(rsp, 1'b0);
  endtask

  task automatic set(input logic [7:0] dv, input logic [7:0] pl,
                     input logic [7:0] cf, input logic [7:0] en,
                     input logic [31:0] lo);
    wr(32'h0000_000C, dv);
    wr(32'h0000_0004, pl);
    wr(32'h0000_0008, cf);
    wr(32'h0000_0000, en);
    wr(32'h0000_0010, lo);
  endtask

  task automatic meas(input int ch, input logic lv, input int p);
    c = 0;
    repeat (p)
    begin
      @(posedge hclk);
      if (pwm_out[ch] === lv)
        c++;
    end
  endtask

  // Bounded wait for pwm_out[ch] to change to lv
  task automatic edge_to(input int ch, input logic lv);
    int t;
    logic pr;
    pr = pwm_out[ch];
    for (t = 0; t < 20000; t++)
    begin
      @(posedge hclk);
      if (pr !== lv && pwm_out[ch] === lv)
        return;
      pr = pwm_out[ch];
    end
    fail("edge wait ran out");
    conclude;
  endtask

  initial
  begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    bad_count = 0;
    check_count = 0;
    seed = 93697;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    chk32(pwm_oe_n, 8'hFF);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (i = 0; i < 8; i++)
      rd(amap[i], 32'h0000_0000);
    $display("reset values done");

    for (i = 0; i < 4; i += (i == 1) ? 2 : 1)
    begin
      d1 = 8'($random(seed));
      wr(amap[i], {24'($random(seed)), d1});
      rd(amap[i], {24'h0, d1});
    end
    wr(32'h0000_0008, 32'h0000_00FF);
    rd(32'h0000_0008, 32'h0000_00FD, 32'h0000_00FD);
    wr(32'h0000_0030, 32'h0000_007F);
    rd(32'h0000_0030, 32'h0000_0003, 32'h0000_007F);
    wr(32'h0000_0010, 32'h1122_3344);
    bus(1'b1, 32'h0000_0012, 32'h00A5_0000, EBP_HSIZE_BYTE);
    rd(32'h0000_0010, 32'h11A5_3344);
    bus(1'b1, 32'h0000_0022, 32'hBEEF_0000, EBP_HSIZE_HALF);
    rd(32'h0000_0020, 32'hBEEF_0000);
    wr(32'h0000_0030, 32'h0000_0080);
    $display("register access done");

    // Every width code, both period lengths, duty rewritten each pass
    for (i = 0; i < 8; i++)
    begin
      n = (256 >> (i / 2)) - (i % 2);
      d1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      d2 = 8'($random(seed));
      pv = {5'h0, 1'($random(seed)), 2'b10};
      set(8'h01, pv, 8'(((i / 2) << 2) | (i % 2)), 8'h03, {d2, d1});
      repeat (2 * n) @(posedge hclk);
      meas(0, 1'b1, n);
      chkn(c, lim(d1, n));
      meas(1, 1'b0, n);
      chkn(c, lim(d2, n));
      chk32(pwm_oe_n, 8'hFC);
      chk32(pwm_out[2], pv[2]);
    end
    $display("width and duty done");

    set(8'h03, 8'h00, 8'h0C, 8'h01, 32'd10);
    repeat (192) @(posedge hclk);
    meas(0, 1'b1, 96);
    chkn(c, 30);
    set(8'h00, 8'h00, 8'h0D, 8'h01, 32'd7);
    repeat (15872) @(posedge hclk);
    meas(0, 1'b1, 7936);
    chkn(c, 1792);
    $display("divisor done");

    set(8'h01, 8'h00, 8'h1C, 8'h07, 32'hFFFF_FFFF);
    // Leaving divide-by-256 can stall ticks up to 256 clocks
    repeat (384) @(posedge hclk);
    c = 0;
    c2 = 0;
    k = 0;
    repeat (64)
    begin
      @(posedge hclk);
      c += (pwm_out[0] === 1'b1);
      c2 += (pwm_out[2] === 1'b1);
      k += (pwm_out[1:0] === 2'b11);
    end
    chkn(c, 32);
    chkn(c2, 64);
    chkn(k, 0);
    edge_to(1, 1'b1);
    repeat (10) @(posedge hclk);
    rd(32'h0000_0008, 32'h0000_001E);
    edge_to(0, 1'b1);
    repeat (10) @(posedge hclk);
    rd(32'h0000_0008, 32'h0000_001C);
    $display("interleave done");

    // Duty edge at count N-16 or N-2 lines up with the cycle-end event
    for (i = 1; i >= 0; i--)
    begin
      set(8'h01, 8'h00, 8'h00, 8'h01, (i == 1) ? 32'd240 : 32'd254);
      repeat (600) @(posedge hclk);
      edge_to(0, 1'b1);
      wr(32'h0000_0030, {24'h0, 1'b1, 5'h0, 1'(i), 1'b1});
      edge_to(0, 1'b0);
      k = 0;
      while (irq !== 1'b1 && k < 8)
      begin
        @(posedge hclk);
        k++;
      end
      chkn(k < 5, 1);
      rd(32'h0000_0030, {24'h0, 1'b1, 5'h0, 1'(i), 1'b1});
      wr(32'h0000_0030, {24'h0, 1'b1, 5'h0, 1'(i), 1'b1});
      rd(32'h0000_0030, {24'h0, 6'h0, 1'(i), 1'b1});
      chk32(irq, 1'b0);
    end
    wr(32'h0000_0030, 32'h0000_0080);
    c = 0;
    repeat (300)
    begin
      @(posedge hclk);
      c += (irq === 1'b1);
    end
    chkn(c, 0);
    rd(32'h0000_0030, 32'h0000_0080);
    wr(32'h0000_0030, 32'h0000_0080);
    rd(32'h0000_0030, 32'h0000_0000);
    $display("cycle end done");
    conclude;
  end
endmodule
